// File: design/umdu_arith.sv
/*
  Single-cycle unsigned multiply and wrapping increment and decrement.
  Assumes operands are stable for the cycle in which results are taken.
*/
`timescale 1ns/100ps
`include "umdu_map.svh"

module umdu_arith (
  input wire logic [`UMDU_WORD_W-1:0] a,
  input wire logic [`UMDU_WORD_W-1:0] b,
  output logic [`UMDU_PROD_W-1:0] product,
  output logic [`UMDU_WORD_W-1:0] incr,
  output logic [`UMDU_WORD_W-1:0] decr
);

  always_comb begin
    product = `UMDU_PROD_W'(a) * `UMDU_PROD_W'(b);
    incr = a + `UMDU_ONE_WORD;
    decr = a - `UMDU_ONE_WORD;
  end

endmodule : umdu_arith

// File: design/umdu_divider.sv
/*
  Serial restoring divider, one quotient bit per clock.
  Assumes the caller guarantees dividend_hi < divisor, so the quotient
  fits one word, and never raises start while busy.
*/
`timescale 1ns/100ps
`include "umdu_map.svh"

module umdu_divider (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [`UMDU_WORD_W-1:0] dividend_hi,
  input wire logic [`UMDU_WORD_W-1:0] dividend_lo,
  input wire logic [`UMDU_WORD_W-1:0] divisor,
  output logic done,
  output logic [`UMDU_WORD_W-1:0] quotient,
  output logic [`UMDU_WORD_W-1:0] remainder
);

  umdu_pkg::umdu_div_state_type s;
  umdu_pkg::umdu_div_state_type next_s;
  logic [`UMDU_WORD_W+1:0] trial;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    trial = {1'b0, s.rem, s.quo[`UMDU_WORD_W-1]} - {2'b00, s.dvs};
    case (s.mode)
      umdu_pkg::UMDU_DIV_IDLE: begin
        if (start) begin
          next_s.rem = dividend_hi;
          next_s.quo = dividend_lo;
          next_s.dvs = divisor;
          next_s.cnt = `UMDU_DIV_STEPS;
          next_s.mode = umdu_pkg::UMDU_DIV_RUN;
        end
      end
      umdu_pkg::UMDU_DIV_RUN: begin
        if (!trial[`UMDU_WORD_W+1]) begin
          next_s.rem = trial[`UMDU_WORD_W-1:0];
          next_s.quo = {s.quo[`UMDU_WORD_W-2:0], 1'b1};
        end else begin
          next_s.rem = {s.rem[`UMDU_WORD_W-2:0], s.quo[`UMDU_WORD_W-1]};
          next_s.quo = {s.quo[`UMDU_WORD_W-2:0], 1'b0};
        end
        next_s.cnt = s.cnt - 1'b1;
        if (s.cnt == `UMDU_LAST_STEP) begin
          next_s.done = 1'b1;
          next_s.mode = umdu_pkg::UMDU_DIV_IDLE;
        end
      end
      default: begin
        next_s.mode = umdu_pkg::UMDU_DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = s.done;
  assign quotient = s.quo;
  assign remainder = s.rem;

endmodule : umdu_divider

// File: design/umdu_top.sv
/*
  Unsigned multiply, 16/16 and 32/16 divide, wrapping increment and
  decrement, with a sticky instruction error flag.
  Assumes the instruction sequencer on the same clock drives operands and
  the enable, and writes results back on the valid strobe.
*/
`timescale 1ns/100ps
`include "umdu_map.svh"

// Notes on behaviour
// - Multiply treats 16-bit operands as unsigned, gives 32-bit product, output ON.
// - Product upper word goes to next destination, lower word to base.
// - Single divide, nonzero divisor: quotient to base, remainder to next, output ON.
// - Zero divisor: either divide skips, output OFF, error flag set.
// - Error flag stays set; only the program's explicit clear or RST_B resets it.
// - Single divide into the K index register writes quotient only.
// - Double divide: 32-bit dividend by 16-bit divisor, quotient and remainder.
// - Double divide quotient overflow: 65535 and 0 written, flag set, output ON.
// - Multiply and divides read all operand bits as unsigned integers.
// - Increment adds one, writes back to the operand, output ON.
// - Increment wraps: 32767 becomes -32768.
// - Decrement subtracts one, writes back to the operand, output ON.
// - Decrement wraps: -32768 becomes 32767.
module umdu_top (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic OP_EN,
  input wire logic [`UMDU_OP_W-1:0] OP_SEL,
  input wire logic [`UMDU_WORD_W-1:0] OPND_A,
  input wire logic [`UMDU_WORD_W-1:0] OPND_A_HI,
  input wire logic [`UMDU_WORD_W-1:0] OPND_B,
  input wire logic DEST_IS_K,
  input wire logic INSTRUCTION_ERROR_FLAG_CLR,
  output logic RES_VALID,
  output logic [`UMDU_WORD_W-1:0] RES_BASE,
  output logic [`UMDU_WORD_W-1:0] RES_NEXT,
  output logic RES_BASE_WE,
  output logic RES_NEXT_WE,
  output logic OP_OUT,
  output logic INSTRUCTION_ERROR_FLAG,
  output logic BUSY
);

  localparam int CHK_DIV_LAT = `UMDU_DIV_LATENCY;

  umdu_pkg::umdu_top_state_type s;
  umdu_pkg::umdu_top_state_type next_s;
  logic go;
  logic b_zero;
  logic ddiv_ovf;
  logic err_set;
  logic div_start;
  logic [`UMDU_WORD_W-1:0] div_hi;
  logic div_done;
  logic [`UMDU_WORD_W-1:0] div_quo;
  logic [`UMDU_WORD_W-1:0] div_rem;
  logic [`UMDU_PROD_W-1:0] product;
  logic [`UMDU_WORD_W-1:0] incr;
  logic [`UMDU_WORD_W-1:0] decr;

  umdu_arith u_arith (
    .a(OPND_A),
    .b(OPND_B),
    .product(product),
    .incr(incr),
    .decr(decr)
  );

  umdu_divider u_div (
    .clk(MCLK),
    .rst_b(RST_B),
    .start(div_start),
    .dividend_hi(div_hi),
    .dividend_lo(OPND_A),
    .divisor(OPND_B),
    .done(div_done),
    .quotient(div_quo),
    .remainder(div_rem)
  );

  assign go = (s.mode == umdu_pkg::UMDU_IDLE) && OP_EN;
  assign b_zero = (OPND_B == `UMDU_ZERO_WORD);
  // High word not below divisor overflows
  assign ddiv_ovf = (OPND_A_HI >= OPND_B);

  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.base_we = 1'b0;
    next_s.next_we = 1'b0;
    err_set = 1'b0;
    div_start = 1'b0;
    div_hi = `UMDU_ZERO_WORD;
    case (s.mode)
      umdu_pkg::UMDU_IDLE: begin
        next_s.op_out = 1'b0;
        if (OP_EN) begin
          next_s.valid = 1'b1;
          case (OP_SEL)
            `UMDU_OP_MUL: begin
              next_s.op_out = 1'b1;
              next_s.base = product[`UMDU_WORD_W-1:0];
              next_s.nxt = product[`UMDU_PROD_W-1:`UMDU_WORD_W];
              next_s.base_we = 1'b1;
              next_s.next_we = 1'b1;
            end
            `UMDU_OP_DIV: begin
              if (b_zero) begin
                err_set = 1'b1;
              end else begin
                next_s.valid = 1'b0;
                div_start = 1'b1;
                next_s.mode = umdu_pkg::UMDU_WAIT;
                next_s.busy = 1'b1;
                next_s.pend_k = DEST_IS_K;
              end
            end
            `UMDU_OP_DDIV: begin
              if (b_zero) begin
                err_set = 1'b1;
              end else if (ddiv_ovf) begin
                err_set = 1'b1;
                next_s.op_out = 1'b1;
                next_s.base = `UMDU_SAT_QUO;
                next_s.nxt = `UMDU_ZERO_WORD;
                next_s.base_we = 1'b1;
                next_s.next_we = 1'b1;
              end else begin
                next_s.valid = 1'b0;
                div_start = 1'b1;
                div_hi = OPND_A_HI;
                next_s.mode = umdu_pkg::UMDU_WAIT;
                next_s.busy = 1'b1;
                next_s.pend_k = 1'b0;
              end
            end
            `UMDU_OP_INC: begin
              next_s.op_out = 1'b1;
              next_s.base = incr;
              next_s.base_we = 1'b1;
            end
            `UMDU_OP_DEC: begin
              next_s.op_out = 1'b1;
              next_s.base = decr;
              next_s.base_we = 1'b1;
            end
            default: begin
              next_s.op_out = 1'b0;
            end
          endcase
        end
      end
      umdu_pkg::UMDU_WAIT: begin
        if (div_done) begin
          next_s.valid = 1'b1;
          next_s.op_out = 1'b1;
          next_s.base = div_quo;
          next_s.nxt = div_rem;
          next_s.base_we = 1'b1;
          next_s.next_we = !s.pend_k;
          next_s.mode = umdu_pkg::UMDU_IDLE;
          next_s.busy = 1'b0;
        end
      end
      default: begin
        next_s.mode = umdu_pkg::UMDU_IDLE;
        next_s.busy = 1'b0;
      end
    endcase
    next_s.err = err_set | (s.err & !INSTRUCTION_ERROR_FLAG_CLR);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_B) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign RES_VALID = s.valid;
  assign RES_BASE = s.base;
  assign RES_NEXT = s.nxt;
  assign RES_BASE_WE = s.base_we;
  assign RES_NEXT_WE = s.next_we;
  assign OP_OUT = s.op_out;
  assign INSTRUCTION_ERROR_FLAG = s.err;
  assign BUSY = s.busy;

  // Checks
  chk_mul_product:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_MUL |=> RES_VALID && OP_OUT &&
    {RES_NEXT, RES_BASE} == `UMDU_PROD_W'($past(OPND_A)) * `UMDU_PROD_W'($past(OPND_B)))
  else $error("multiply product or output wrong");

  chk_mul_split:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_MUL |=> RES_BASE_WE && RES_NEXT_WE &&
    RES_BASE == `UMDU_WORD_W'($past(OPND_A) * $past(OPND_B)) &&
    `UMDU_PROD_W'(RES_NEXT) ==
    (`UMDU_PROD_W'($past(OPND_A)) * `UMDU_PROD_W'($past(OPND_B))) >> `UMDU_WORD_W)
  else $error("product words not split upper to next");

  chk_div_result:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_DIV && !b_zero |-> ##CHK_DIV_LAT
    (RES_VALID && OP_OUT && RES_BASE_WE &&
    RES_BASE == $past(OPND_A, CHK_DIV_LAT) / $past(OPND_B, CHK_DIV_LAT) &&
    RES_NEXT == $past(OPND_A, CHK_DIV_LAT) % $past(OPND_B, CHK_DIV_LAT)))
  else $error("single divide result wrong");

  chk_zero_divisor:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && (OP_SEL == `UMDU_OP_DIV || OP_SEL == `UMDU_OP_DDIV) && b_zero |=>
    RES_VALID && !OP_OUT && !RES_BASE_WE && !RES_NEXT_WE && INSTRUCTION_ERROR_FLAG)
  else $error("zero divisor not skipped with error");

  chk_err_sticky:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    INSTRUCTION_ERROR_FLAG && !INSTRUCTION_ERROR_FLAG_CLR |=> INSTRUCTION_ERROR_FLAG)
  else $error("error flag dropped without clear");

  chk_err_source:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    $rose(INSTRUCTION_ERROR_FLAG) |-> $past(err_set))
  else $error("error flag rose without an error");

  chk_k_drop:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_DIV && !b_zero && DEST_IS_K |-> ##CHK_DIV_LAT
    (RES_VALID && RES_BASE_WE && !RES_NEXT_WE))
  else $error("remainder written for K destination");

  chk_ddiv_result:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_DDIV && !b_zero && !ddiv_ovf |-> ##CHK_DIV_LAT
    (RES_VALID && OP_OUT && RES_NEXT_WE &&
    `UMDU_PROD_W'(RES_BASE) * `UMDU_PROD_W'($past(OPND_B, CHK_DIV_LAT)) +
    `UMDU_PROD_W'(RES_NEXT) ==
    {$past(OPND_A_HI, CHK_DIV_LAT), $past(OPND_A, CHK_DIV_LAT)} &&
    RES_NEXT < $past(OPND_B, CHK_DIV_LAT)))
  else $error("double divide result wrong");

  chk_ddiv_saturate:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_DDIV && !b_zero && ddiv_ovf |=>
    RES_VALID && OP_OUT && RES_BASE == `UMDU_SAT_QUO &&
    RES_NEXT == `UMDU_ZERO_WORD && INSTRUCTION_ERROR_FLAG)
  else $error("double divide overflow not saturated");

  chk_inc_value:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_INC |=> RES_VALID && OP_OUT && RES_BASE_WE &&
    !RES_NEXT_WE && RES_BASE == $past(OPND_A) + `UMDU_ONE_WORD)
  else $error("increment result wrong");

  chk_inc_wrap:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_INC && OPND_A == `UMDU_POS_MAX |=>
    RES_BASE == `UMDU_NEG_MIN)
  else $error("increment did not wrap");

  chk_dec_value:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_DEC |=> RES_VALID && OP_OUT && RES_BASE_WE &&
    !RES_NEXT_WE && RES_BASE == $past(OPND_A) - `UMDU_ONE_WORD)
  else $error("decrement result wrong");

  chk_dec_wrap:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    go && OP_SEL == `UMDU_OP_DEC && OPND_A == `UMDU_NEG_MIN |=>
    RES_BASE == `UMDU_POS_MAX)
  else $error("decrement did not wrap");

  chk_valid_cause:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    RES_VALID |-> $past(go) || $past(div_done))
  else $error("valid strobe without cause");

  chk_idle_off:
  assert property (@(posedge MCLK) disable iff (!RST_B)
    !OP_EN && !BUSY |=> !OP_OUT && !RES_VALID)
  else $error("output on while not enabled");

endmodule : umdu_top

// File: pkg/umdu_map.svh
/*
  Constants of the unsigned multiply, divide and increment/decrement unit:
  word widths, operation codes, step counts and limit values.
  Assumes it is included by bare name before any user of the macros.
*/
`ifndef UMDU_MAP_SVH
`define UMDU_MAP_SVH

`define UMDU_WORD_W 16
`define UMDU_PROD_W 32
`define UMDU_OP_W 3
`define UMDU_CNT_W 5

`define UMDU_OP_MUL 3'h0
`define UMDU_OP_DIV 3'h1
`define UMDU_OP_DDIV 3'h2
`define UMDU_OP_INC 3'h3
`define UMDU_OP_DEC 3'h4

`define UMDU_DIV_STEPS 5'h10
`define UMDU_LAST_STEP 5'h01
`define UMDU_DIV_LATENCY 18

`define UMDU_ZERO_WORD 16'h0000
`define UMDU_ONE_WORD 16'h0001
`define UMDU_SAT_QUO 16'hffff
`define UMDU_POS_MAX 16'h7fff
`define UMDU_NEG_MIN 16'h8000

`endif

// File: pkg/umdu_pkg.sv
/*
  Types of the unsigned multiply, divide and increment/decrement unit.
  Assumes umdu_map.svh is on the include path.
*/
`include "umdu_map.svh"

package umdu_pkg;

  typedef enum logic [0:0] {
    UMDU_IDLE,
    UMDU_WAIT
  } umdu_mode_type;

  typedef enum logic [0:0] {
    UMDU_DIV_IDLE,
    UMDU_DIV_RUN
  } umdu_div_mode_type;

  typedef struct packed {
    umdu_mode_type mode;
    logic valid;
    logic [`UMDU_WORD_W-1:0] base;
    logic [`UMDU_WORD_W-1:0] nxt;
    logic base_we;
    logic next_we;
    logic op_out;
    logic err;
    logic busy;
    logic pend_k;
  } umdu_top_state_type;

  typedef struct packed {
    umdu_div_mode_type mode;
    logic [`UMDU_CNT_W-1:0] cnt;
    logic [`UMDU_WORD_W-1:0] rem;
    logic [`UMDU_WORD_W-1:0] quo;
    logic [`UMDU_WORD_W-1:0] dvs;
    logic done;
  } umdu_div_state_type;

endpackage : umdu_pkg

// File: tb/testbench.sv
/*
  Self-checking bench for the multiply, divide, increment and decrement unit.
  Assumes umdu_map.svh on the include path and the sequencer model beside it.
*/
`timescale 1ns/100ps
`include "umdu_map.svh"

module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic op_en, dest_is_k, flag_clr, res_valid, bwe, nwe, op_out, err_flag;
  logic busy;
  logic [2:0] op_sel;
  logic [15:0] opnd_a, opnd_a_hi, opnd_b, res_base, res_next;
  int miscompares = 0;
  int check_count = 0;

  initial begin
    forever #5 mclk = ~mclk;
  end

  umdu_seq_model u_seq (.mclk(mclk), .res_valid(res_valid), .busy(busy), .op_en(op_en),
    .op_sel(op_sel),
    .opnd_a(opnd_a), .opnd_a_hi(opnd_a_hi), .opnd_b(opnd_b), .dest_is_k(dest_is_k),
    .flag_clr(flag_clr));

  umdu_top u_dut (.MCLK(mclk), .RST_B(rst_b), .OP_EN(op_en), .OP_SEL(op_sel),
    .OPND_A(opnd_a), .OPND_A_HI(opnd_a_hi), .OPND_B(opnd_b), .DEST_IS_K(dest_is_k),
    .INSTRUCTION_ERROR_FLAG_CLR(flag_clr), .RES_VALID(res_valid), .RES_BASE(res_base),
    .RES_NEXT(res_next), .RES_BASE_WE(bwe), .RES_NEXT_WE(nwe), .OP_OUT(op_out),
    .INSTRUCTION_ERROR_FLAG(err_flag), .BUSY(busy));

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  // Expected flags are {base we, next we, output bit, error flag}
  task automatic run(input logic [2:0] op, input logic [15:0] a, input logic [15:0] ahi,
      input logic [15:0] b, input logic k, input logic [15:0] eb, input logic [15:0] en,
      input logic [3:0] ex, input int elat);
    u_seq.issue(op, a, ahi, b, k);
    check(res_valid, 1'b1, "valid strobe");
    if (res_valid !== 1'b1) begin
      close_out();
    end
    if (ex[3]) begin
      check(res_base, eb, "base word");
    end
    if (ex[2]) begin
      check(res_next, en, "next word");
    end
    check({bwe, nwe, op_out, err_flag}, ex, "write enables, output, flag");
    check(u_seq.lat, elat == 0 ? `UMDU_DIV_LATENCY : elat, "latency");
    check(u_seq.busy_cycles, elat == 0 ? `UMDU_DIV_LATENCY - 1 : 0, "busy cycles");
  endtask : run

  task automatic t_mul();
    logic [15:0] ma [3] = '{16'hcd14, 16'hffff, 16'h8000};
    logic [15:0] mb [3] = '{16'h001e, 16'hffff, 16'h0002};
    logic [31:0] p;
    for (int i = 0; i < 3; i++) begin
      p = {16'h0000, ma[i]} * {16'h0000, mb[i]};
      run(`UMDU_OP_MUL, ma[i], 16'h0000, mb[i], 1'b0, p[15:0], p[31:16], 4'he, 1);
    end
    $display("test multiply done");
  endtask : t_mul

  task automatic t_div();
    logic [15:0] da [3] = '{16'hd431, 16'hffff, 16'h8000};
    logic [15:0] db [3] = '{16'h012c, 16'h0001, 16'h0003};
    for (int i = 0; i < 3; i++) begin
      run(`UMDU_OP_DIV, da[i], 16'h0000, db[i], 1'b0, da[i] / db[i], da[i] % db[i], 4'he, 0);
    end
    run(`UMDU_OP_DIV, da[0], 16'h0000, db[0], 1'b1, da[0] / db[0], 16'h0000, 4'ha, 0);
    $display("test divide done");
  endtask : t_div

  task automatic t_incdec();
    logic [2:0] op [5] = '{`UMDU_OP_INC, `UMDU_OP_DEC, `UMDU_OP_INC, `UMDU_OP_DEC, `UMDU_OP_INC};
    logic [15:0] v [5] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0000, 16'h02ee};
    for (int i = 0; i < 5; i++) begin
      run(op[i], v[i], 16'h0000, 16'h0000, 1'b0, op[i] == `UMDU_OP_INC ? v[i] + 16'h0001 : v[i] - 16'h0001, 16'h0000, 4'ha, 1);
    end
    $display("test increment decrement done");
  endtask : t_incdec

  task automatic t_ddiv();
    logic [31:0] d [2] = '{32'h000511e1, 32'hfffeffff};
    logic [15:0] b [2] = '{16'h0fa0, 16'hffff};
    logic [31:0] q, r;
    for (int i = 0; i < 2; i++) begin
      q = d[i] / {16'h0000, b[i]};
      r = d[i] % {16'h0000, b[i]};
      run(`UMDU_OP_DDIV, d[i][15:0], d[i][31:16], b[i], 1'b0, q[15:0], r[15:0], 4'he, 0);
    end
    run(`UMDU_OP_DDIV, 16'h0000, 16'h0003, 16'h0003, 1'b0, 16'hffff, 16'h0000, 4'hf, 1);
    $display("test double divide done");
  endtask : t_ddiv

  task automatic t_flag();
    u_seq.clear_flag();
    check(err_flag, 1'b0, "flag after clear");
    run(`UMDU_OP_DIV, 16'h1234, 16'h0000, 16'h0000, 1'b0, 16'h0000, 16'h0000, 4'h1, 1);
    run(`UMDU_OP_MUL, 16'h0002, 16'h0000, 16'h0003, 1'b0, 16'h0006, 16'h0000, 4'hf, 1);
    u_seq.clear_flag();
    run(`UMDU_OP_DDIV, 16'h1234, 16'h0000, 16'h0000, 1'b0, 16'h0000, 16'h0000, 4'h1, 1);
    u_seq.clear_flag();
    check(err_flag, 1'b0, "flag after second clear");
    $display("test error flag done");
  endtask : t_flag

  task automatic t_idle();
    run(`UMDU_OP_INC, 16'h0010, 16'h0000, 16'h0000, 1'b0, 16'h0011, 16'h0000, 4'ha, 1);
    @(posedge mclk);
    check(op_out, 1'b0, "output bit after idle");
    $display("test idle done");
  endtask : t_idle

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    check({res_valid, bwe, nwe, op_out, err_flag}, 5'h00, "outputs after reset");
    t_mul();
    t_div();
    t_incdec();
    t_ddiv();
    t_flag();
    t_idle();
    close_out();
  end
endmodule : testbench

// File: tb/umdu_seq_model.sv
/*
  Instruction sequencer model: issues one operation, waits for its result.
  Assumes a unit with the umdu_top ports on the same rising clock.
*/
`timescale 1ns/100ps
`include "umdu_map.svh"

module umdu_seq_model (
  input wire logic mclk,
  input wire logic res_valid,
  input wire logic busy,
  output logic op_en,
  output logic [`UMDU_OP_W-1:0] op_sel,
  output logic [`UMDU_WORD_W-1:0] opnd_a,
  output logic [`UMDU_WORD_W-1:0] opnd_a_hi,
  output logic [`UMDU_WORD_W-1:0] opnd_b,
  output logic dest_is_k,
  output logic flag_clr
);
  int lat;
  int busy_cycles;

  initial begin
    op_en = 1'b0;
    op_sel = 3'h7;
    opnd_a = 16'h0000;
    opnd_a_hi = 16'h0000;
    opnd_b = 16'h0000;
    dest_is_k = 1'b0;
    flag_clr = 1'b0;
    lat = 0;
    busy_cycles = 0;
  end

  // One request, operands held to taking edge
  task automatic issue(input logic [2:0] op, input logic [15:0] a, input logic [15:0] ahi,
      input logic [15:0] b, input logic k);
    @(posedge mclk);
    op_en <= 1'b1;
    op_sel <= op;
    opnd_a <= a;
    opnd_a_hi <= ahi;
    opnd_b <= b;
    dest_is_k <= k;
    @(posedge mclk);
    op_en <= 1'b0;
    opnd_a <= ~a;
    opnd_a_hi <= ~ahi;
    opnd_b <= ~b;
    dest_is_k <= ~k;
    lat = 0;
    busy_cycles = 0;
    do begin
      @(posedge mclk);
      lat++;
      if (busy === 1'b1) begin
        busy_cycles++;
      end
    end while (res_valid !== 1'b1 && lat < 40);
  endtask : issue

  task automatic clear_flag();
    @(posedge mclk);
    flag_clr <= 1'b1;
    @(posedge mclk);
    flag_clr <= 1'b0;
    @(posedge mclk);
  endtask : clear_flag
endmodule : umdu_seq_model
